// ---- rtl/rxlt_pkg.sv ----
// package for the receive line input and data-link tap
package rxlt_pkg;
    // rail pair codes: {pos, neg}
    localparam logic [1:0] RAIL_NONE = 2'h0;
    localparam logic [1:0] RAIL_NEG = 2'h1;
    localparam logic [1:0] RAIL_POS = 2'h2;
    localparam logic [1:0] RAIL_BAD = 2'h3;
    localparam logic [1:0] RESET_RAILS = 2'h0;

    // decoded line pulse
    typedef struct packed {
        logic pulse;
        logic neg;
        logic invalid;
    } rxlt_pulse_t;

    // word carried through the buffer toward the data-link pins
    typedef struct packed {
        logic data;
        logic mark;
    } rxlt_dl_bit_t;

    localparam int BUF_DEPTH = 2;
endpackage

// ---- rtl/rxlt_line_tap.sv ----
// receive line sampling, rail decode and data-link tap
// Function
// R1: line data on rails or nrz input is sampled by the receive line clock.
// R2: the nrz input gives one bit per receive clock, taken on its rising edge.
// R3: rails 00 no pulse, 01 negative, 10 positive, 11 invalid but counted as a pulse.
// R4: both rail inputs are sampled on the rising receive clock edge.
// R5: with unipolar nrz on one rail the outside ties the other rail to ground.
// R6: with unipolar nrz software selects bipolar format and disables violation counting.
// R7: received nrz data leaves on the data-link output, changing on the falling clock edge.
// R8: every received bit appears on the data-link output, not only selected slots.
// R9: selected data-link bit positions are marked by gapped data-link clock pulses.
// R10: the gapped clock is high during the low clock phase of each selected bit.
// R11: outside selected bits the gapped clock stays low.
// R12: selected bits come from a slot selection input driven by framer control.
module rxlt_line_tap
#(
    parameter int DEPTH = rxlt_pkg::BUF_DEPTH
)
(
    // line clock and reset
    input wire logic rx_line_clk_in,
    input wire logic reset_n_in,
    // line side inputs
    input wire logic rx_nrz_data_in,
    input wire logic rx_pos_rail_in,
    input wire logic rx_neg_rail_in,
    // configuration from framer control
    input wire logic rx_bipolar_format_sel,
    input wire logic dl_slot_select_in,
    // decoded pulse toward the framer
    output rxlt_pkg::rxlt_pulse_t rx_pulse_out,
    output logic rx_nrz_data_out,
    // data-link pins
    output logic rx_clk_out,
    output logic rx_datalink_data_out,
    output logic rx_datalink_gapped_clk_out,
    output logic dl_overflow_out
);
    import rxlt_pkg::*;

    // the buffer indexing below is written for exactly two entries
    if (DEPTH != BUF_DEPTH)
    begin
        $error("rxlt_line_tap: only a two-entry buffer is supported");
    end

    logic [1:0] rails_q;
    logic nrz_q;
    logic samp_valid_q;
    logic slot_q;
    rxlt_pulse_t pulse_d;
    rxlt_pulse_t pulse_q;
    rxlt_dl_bit_t buf_q [DEPTH];
    logic [1:0] count_q;
    logic wr_valid;
    logic wr_ready;
    logic rd_valid;
    logic rd_ready;
    rxlt_dl_bit_t wr_word;
    rxlt_dl_bit_t head_word;
    logic dl_data_q;
    logic dl_mark_q;

    // rising edge capture of rails and nrz input
    always_ff @(posedge rx_line_clk_in)
    begin
        if (!reset_n_in)
        begin
            rails_q <= RESET_RAILS;
            nrz_q <= 1'b0;
            slot_q <= 1'b0;
            samp_valid_q <= 1'b0;
        end
        else
        begin
            rails_q <= {rx_pos_rail_in, rx_neg_rail_in}; // R1 R4
            nrz_q <= rx_nrz_data_in; // R1 R2
            slot_q <= dl_slot_select_in; // R12
            samp_valid_q <= 1'b1;
        end
    end

    always_comb
    begin
        pulse_d = '0;
        case (rails_q) // R3
            RAIL_NONE: pulse_d = '0;
            RAIL_NEG: pulse_d = '{pulse: 1'b1, neg: 1'b1, invalid: 1'b0};
            RAIL_POS: pulse_d = '{pulse: 1'b1, neg: 1'b0, invalid: 1'b0};
            default: pulse_d = '{pulse: 1'b1, neg: 1'b0, invalid: 1'b1};
        endcase
    end

    always_ff @(posedge rx_line_clk_in)
    begin
        if (!reset_n_in)
        begin
            pulse_q <= '0;
        end
        else
        begin
            pulse_q <= pulse_d;
        end
    end

    assign rx_pulse_out = pulse_q;
    // in bipolar mode the data bit is the presence of a pulse; else the nrz pin
    assign rx_nrz_data_out = rx_bipolar_format_sel ? pulse_q.pulse : nrz_q;

    // two-entry buffer; the drain takes one word per clock so it never stalls
    // in practice, but an overflow is flagged rather than silently dropped
    assign wr_valid = samp_valid_q;
    assign wr_word = '{data: rx_bipolar_format_sel ? pulse_d.pulse : nrz_q, mark: slot_q};
    assign wr_ready = (count_q != 2'(DEPTH)) || rd_ready;
    assign rd_valid = (count_q != 2'h0);
    assign rd_ready = 1'b1;

    always_ff @(posedge rx_line_clk_in)
    begin
        if (!reset_n_in)
        begin
            count_q <= 2'h0;
            buf_q[0] <= '0;
            buf_q[1] <= '0;
            dl_overflow_out <= 1'b0;
        end
        else
        begin
            dl_overflow_out <= wr_valid && !wr_ready;
            if (rd_valid && rd_ready)
            begin
                buf_q[0] <= buf_q[1];
            end
            if (wr_valid && wr_ready)
            begin
                if (rd_valid && rd_ready)
                begin
                    buf_q[count_q[1]] <= wr_word;
                end
                else
                begin
                    buf_q[count_q[0]] <= wr_word;
                end
            end
            count_q <= count_q + 2'((wr_valid && wr_ready) ? 1 : 0)
                - 2'((rd_valid && rd_ready) ? 1 : 0);
        end
    end

    always_comb
    begin
        head_word = buf_q[0];
    end

    // data-link output changes on the falling line clock edge
    always_ff @(negedge rx_line_clk_in)
    begin
        if (!reset_n_in)
        begin
            dl_data_q <= 1'b0;
            dl_mark_q <= 1'b0;
        end
        else if (rd_valid)
        begin
            dl_data_q <= head_word.data; // R7 R8
            dl_mark_q <= head_word.mark; // R9 R12
        end
        else
        begin
            dl_mark_q <= 1'b0; // R11
        end
    end

    assign rx_datalink_data_out = dl_data_q;
    assign rx_clk_out = rx_line_clk_in;
    // gapped clock: high only while the line clock is low in a marked bit
    assign rx_datalink_gapped_clk_out = dl_mark_q && !rx_line_clk_in; // R10 R11


    // sampled at the rise, the gapped clock shows the low phase just ending
    a_gap_marks_slot: assert property (@(posedge rx_line_clk_in) // R10
        disable iff (!reset_n_in)
        rx_datalink_gapped_clk_out == $past(dl_slot_select_in, 2))
        else $error("gapped clock low phase does not follow slot select");
    a_rail_decode_bad: assert property (@(posedge rx_line_clk_in) // R3
        disable iff (!reset_n_in)
        (rails_q == RAIL_BAD) |=> rx_pulse_out.pulse && rx_pulse_out.invalid)
        else $error("invalid rail pair not decoded as pulse");
    a_rail_decode_neg: assert property (@(posedge rx_line_clk_in) // R4
        disable iff (!reset_n_in)
        rx_neg_rail_in && !rx_pos_rail_in |=> ##1 rx_pulse_out.neg && rx_pulse_out.pulse)
        else $error("negative rail not decoded");
    a_rail_none: assert property (@(posedge rx_line_clk_in) // R1
        disable iff (!reset_n_in)
        !rx_neg_rail_in && !rx_pos_rail_in |=> ##1 !rx_pulse_out.pulse)
        else $error("pulse decoded with no rail active");
    a_nrz_capture: assert property (@(posedge rx_line_clk_in) // R2
        disable iff (!reset_n_in)
        !rx_bipolar_format_sel && !$past(rx_bipolar_format_sel)
        |-> rx_nrz_data_out == $past(rx_nrz_data_in))
        else $error("nrz bit not captured on rising edge");
    a_dl_data_bit: assert property (@(posedge rx_line_clk_in) // R8
        disable iff (!reset_n_in)
        $past(rx_bipolar_format_sel)
        |-> rx_datalink_data_out == ($past(rx_pos_rail_in, 2) || $past(rx_neg_rail_in, 2)))
        else $error("data-link bit does not match the received pulse");
    a_dl_data_nrz: assert property (@(posedge rx_line_clk_in) // R7
        disable iff (!reset_n_in)
        !$past(rx_bipolar_format_sel)
        |-> rx_datalink_data_out == $past(rx_nrz_data_in, 2))
        else $error("data-link bit does not match the nrz input");
    a_no_overflow: assert property (@(posedge rx_line_clk_in) // R8
        disable iff (!reset_n_in)
        !dl_overflow_out)
        else $error("data-link buffer dropped a bit");
    a_buf_count: assert property (@(posedge rx_line_clk_in) // R8
        disable iff (!reset_n_in)
        count_q <= 2'(DEPTH))
        else $error("buffer count beyond depth");
    a_mark_source: assert property (@(negedge rx_line_clk_in) // R11
        disable iff (!reset_n_in)
        !rd_valid |=> !dl_mark_q)
        else $error("mark held without buffered bit");
endmodule

// ---- bench/rxlt_line_model.sv ----
// line interface model driving the rail pair and the nrz pin
module rxlt_line_model
(
    input wire logic clk_in,
    input wire logic rbit_in,
    input wire logic nbit_in,
    input wire logic bad_in,
    input wire logic uni_in,
    input wire logic uni_neg_in,
    output logic pos_out,
    output logic neg_out,
    output logic nrz_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pol_q = 1'b0;
    // marks alternate polarity, as a real ami line does
    always @(posedge clk_in)
        if (rbit_in)
            pol_q <= ~pol_q;
    always_comb
    begin
        if (uni_in)
            {pos_out, neg_out} = uni_neg_in ? {1'b0, rbit_in} : {rbit_in, 1'b0};
        else if (bad_in)
            {pos_out, neg_out} = 2'h3;
        else
            {pos_out, neg_out} = rbit_in ? {pol_q, ~pol_q} : 2'h0;
        nrz_out = nbit_in;
    end
endmodule

// ---- bench/rxlt_line_tap_tb_top.sv ----
// self-checking bench for the receive line tap
module rxlt_line_tap_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rxlt_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, rbit = 1'b0, nbit = 1'b0, bad = 1'b0;
    logic uni = 1'b0, uneg = 1'b0, fmt = 1'b1, sel = 1'b0, last_dld = 1'b0;
    logic pos, neg, nrz, ovf, gck, dld, nrzo, cko;
    rxlt_pulse_t pulse;
    logic [3:0] h0 = 4'h0, h1 = 4'h0;
    int seed = 67014;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int skip = 4;
    initial forever #4 clk = ~clk;
    rxlt_line_model u_lim(.clk_in(clk), .rbit_in(rbit), .nbit_in(nbit), .bad_in(bad),
        .uni_in(uni), .uni_neg_in(uneg), .pos_out(pos), .neg_out(neg), .nrz_out(nrz));
    rxlt_line_tap u_dut(.rx_line_clk_in(clk), .reset_n_in(reset_n), .rx_nrz_data_in(nrz),
        .rx_pos_rail_in(pos), .rx_neg_rail_in(neg), .rx_bipolar_format_sel(fmt),
        .dl_slot_select_in(sel), .rx_pulse_out(pulse), .rx_nrz_data_out(nrzo),
        .rx_clk_out(cko), .rx_datalink_data_out(dld), .rx_datalink_gapped_clk_out(gck),
        .dl_overflow_out(ovf));
    function automatic logic dl_bit(input logic [3:0] h, input logic f);
        return f ? (h[3] | h[2]) : h[1];
    endfunction
    task automatic check(input string what, input logic [2:0] exp, input logic [2:0] got);
        total_checks++;
        if (exp !== got)
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        if (exp !== got)
            err_count++;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // history holds {pos, neg, nrz, select} as seen at the last two rising edges
    always @(posedge clk)
    begin
        h1 = h0;
        h0 = {pos, neg, nrz, sel};
        cycles++;
        if (skip > 0)
            skip--;
        if (cycles > 2000)
            err_count++;
        if (cycles > 2000)
            conclude();
        #2;
        if (reset_n && skip == 0)
        begin
            check("gapped clk in high phase", 3'h0, {2'h0, gck});
            check("dl data held over rise", {2'h0, last_dld}, {2'h0, dld});
        end
    end
    always @(negedge clk)
    begin
        #1;
        last_dld = dld;
        if (reset_n && skip == 0)
        begin
            check("pulse", {1'b0, h1[3] | h1[2], h1[3] & h1[2]}, {1'b0, pulse.pulse, pulse.invalid});
            if (h1[3] ^ h1[2])
                check("polarity", {2'h0, h1[2]}, {2'h0, pulse.neg});
            check("dl data", {2'h0, dl_bit(h1, fmt)}, {2'h0, dld});
            check("gapped clk in low phase", {2'h0, h1[0]}, {2'h0, gck});
            check("clk out low", 3'h0, {2'h0, cko});
            check("nrz out", {2'h0, fmt ? (h1[3] | h1[2]) : h0[1]}, {2'h0, nrzo});
            check("overflow", 3'h0, {2'h0, ovf});
        end
    end
    task automatic run(input string name, input logic f, input logic u, input logic un,
        input logic b, input int n);
        fmt = f;
        uni = u;
        uneg = un;
        skip = 4;
        repeat (n)
        begin
            @(posedge clk);
            #1;
            rbit = 1'($random(seed));
            nbit = 1'($random(seed));
            sel = 1'($random(seed));
            bad = b | (($random(seed) & 7) == 0);
        end
        $display("test %s done", name);
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        #1;
        check("reset outputs", 3'h0, {pulse.pulse, gck, dld});
        reset_n = 1'b1;
        skip = 4;
        run("ami random", 1'b1, 1'b0, 1'b0, 1'b0, 200);
        run("invalid burst", 1'b1, 1'b0, 1'b0, 1'b1, 20);
        // unipolar data on one rail needs bipolar format selected
        run("unipolar pos", 1'b1, 1'b1, 1'b0, 1'b0, 100);
        run("unipolar neg", 1'b1, 1'b1, 1'b1, 1'b0, 100);
        run("nrz pin", 1'b0, 1'b0, 1'b0, 1'b0, 200);
        conclude();
    end
endmodule
